/* File: hw/cmp_skip_pkg.sv */
// constants and types for the compare-and-skip-if-greater execution block
// Summary of operation
// - recognise opcode 0110 010a in upper byte; lower byte is file address
// - compare file byte with working register by unsigned subtraction, difference discarded
// - file byte greater than working register: discard fetched instruction, run no-op
// - one cycle no skip, two skipping one word, three skipping two words
// - access bit 0 resolves file address inside the fixed access bank
// - access bit 1 uses bank select register to choose the bank
// - extended set, access bit 0, address 95 or less: indexed literal offset
package cmp_skip_pkg;
   localparam logic [6:0]  OPC_CPSG      = 7'h32;   // 0110 010
   localparam int          OPC_MSB       = 15;
   localparam int          OPC_LSB       = 9;
   localparam int          ABIT_POS      = 8;
   localparam logic [7:0]  LIT_OFS_MAX   = 8'h5f;
   localparam logic [7:0]  ACC_SPLIT     = 8'h60;   // low 96 bytes of access bank below this
   localparam logic [3:0]  ACC_HI_BANK   = 4'hf;
   localparam logic [3:0]  ACC_LO_BANK   = 4'h0;
   localparam logic [1:0]  QPH_LAST      = 2'h3;
   localparam logic [1:0]  QPH_FIRST     = 2'h0;    // decode phase, also the read phase
   localparam logic [11:0] ADDR_RST      = 12'h000;
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SKIP1, ST_SKIP2} exec_state_e;
endpackage

/* File: hw/operand_addr.sv */
// operand address resolution for byte-oriented file access
`timescale 1ns/1ps
module operand_addr
   import cmp_skip_pkg::*;
(
   input  wire logic [7:0]  file_addr,        // 8-bit address field
   input  wire logic        access_bit,       // bank-access bit
   input  wire logic [3:0]  bank_select_register, // bank select contents
   input  wire logic        ext_set_en,       // extended instruction set enabled
   input  wire logic [11:0] index_base,       // index pointer for literal offset mode
   output logic      [11:0] data_addr,        // resolved data memory address
   output logic             lit_ofs_mode      // literal offset mode taken
);
   wire logic [11:0] acc_addr;
   wire logic [11:0] bsr_addr;
   wire logic [11:0] idx_addr;
   assign lit_ofs_mode = ext_set_en && !access_bit && (file_addr <= LIT_OFS_MAX);
   assign acc_addr = (file_addr < ACC_SPLIT) ? {ACC_LO_BANK, file_addr}
                                             : {ACC_HI_BANK, file_addr};
   assign bsr_addr = {bank_select_register, file_addr};
   assign idx_addr = index_base + {4'h0, file_addr};
   assign data_addr = lit_ofs_mode ? idx_addr : (access_bit ? bsr_addr : acc_addr);
endmodule

/* File: hw/cmp_skip_gt.sv */
// execution of the compare-and-skip-if-greater instruction
`timescale 1ns/1ps
module cmp_skip_gt
   import cmp_skip_pkg::*;
(
   input  wire logic        core_clk,         // core clock, 40 MHz
   input  wire logic        nrst,             // async reset, active low
   input  wire logic        instr_valid,      // instr_word holds a new instruction at Q1
   input  wire logic [15:0] instr_word,       // instruction word
   input  wire logic        next_is_two_word, // fetched next instruction is two words
   input  wire logic [7:0]  working_register_file_alias, // working register value
   input  wire logic [3:0]  bank_select_register, // bank select contents
   input  wire logic        ext_set_en,       // extended instruction set enabled
   input  wire logic [11:0] index_base,       // index pointer for literal offset mode
   input  wire logic [7:0]  mem_rdata,        // data memory read data
   output logic             is_cmp_skip,      // instruction recognised (held for cycle)
   output logic [11:0]      mem_addr,         // data memory read address
   output logic             mem_rd,           // data memory read strobe
   output logic             skip_taken,       // pulse: skip decided
   output logic             force_nop,        // fetched word replaced by no-op
   output logic             busy              // instruction in progress
);
   import cmp_skip_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   exec_state_e  state_reg;
   exec_state_e  state_next;
   logic  [1:0]  qph_reg;
   logic         two_reg;
   logic  [7:0]  faddr_reg;
   logic         abit_reg;
   wire logic [11:0] res_addr;
   wire logic        lit_mode;
   wire logic        decode_hit;
   wire logic [8:0]  diff;
   wire logic        greater;
   wire logic        cyc_end;
   wire logic        in_idle;
   wire logic        in_exec;
   wire logic        in_skip;
   wire logic        take_instr;
   wire logic        exec_read;
   wire logic        exec_done;
   wire logic        skip_now;
   wire logic        enter_exec;
   wire logic        enter_skip;
   wire logic        stay_busy;

   assign decode_hit = instr_valid && (instr_word[OPC_MSB:OPC_LSB] == OPC_CPSG);
   // borrow clear and nonzero difference means file byte exceeds working register
   assign diff    = {1'b0, mem_rdata} - {1'b0, working_register_file_alias};
   assign greater = !diff[8] && (diff[7:0] != 8'h00);
   assign cyc_end = (qph_reg == QPH_LAST);
   assign in_idle    = (state_reg == ST_IDLE);
   assign in_exec    = (state_reg == ST_EXEC);
   assign in_skip    = (state_reg == ST_SKIP1) || (state_reg == ST_SKIP2);
   // a word offered while an instruction is in progress is dropped
   assign take_instr = in_idle && decode_hit;
   assign exec_read  = in_exec && (qph_reg == QPH_FIRST);
   assign exec_done  = in_exec && cyc_end;
   assign skip_now   = exec_done && greater;
   assign enter_exec = (state_next == ST_EXEC);
   assign enter_skip = (state_next == ST_SKIP1) || (state_next == ST_SKIP2);
   assign stay_busy  = (state_next != ST_IDLE);

   operand_addr u_addr (
      .file_addr            (faddr_reg),
      .access_bit           (abit_reg),
      .bank_select_register (bank_select_register),
      .ext_set_en           (ext_set_en),
      .index_base           (index_base),
      .data_addr            (res_addr),
      .lit_ofs_mode         (lit_mode)
   );

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:  if (decode_hit) state_next = ST_EXEC;
         ST_EXEC:  if (cyc_end) state_next = greater ? ST_SKIP1 : ST_IDLE;
         ST_SKIP1: if (cyc_end) state_next = two_reg ? ST_SKIP2 : ST_IDLE;
         ST_SKIP2: if (cyc_end) state_next = ST_IDLE;
         default:  state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // phase count restarts at the decode edge so the execute cycle gets all four phases
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         qph_reg <= QPH_FIRST;
      end else if (in_idle) begin
         qph_reg <= QPH_FIRST;
      end else begin
         qph_reg <= qph_reg + 2'h1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         faddr_reg <= 8'h00;
         abit_reg  <= 1'b0;
      end else if (take_instr) begin
         faddr_reg <= instr_word[7:0];
         abit_reg  <= instr_word[ABIT_POS];
      end
   end

   // length of the skipped instruction is fixed at the last execute phase
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         two_reg <= 1'b0;
      end else if (exec_done) begin
         two_reg <= next_is_two_word;
      end
   end

   // outputs registered; no write port exists, so no state outside changes
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         is_cmp_skip <= 1'b0;
         busy        <= 1'b0;
      end else begin
         is_cmp_skip <= enter_exec;
         busy        <= stay_busy;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         mem_addr <= ADDR_RST;
         mem_rd   <= 1'b0;
      end else begin
         mem_addr <= res_addr;
         mem_rd   <= exec_read;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         skip_taken <= 1'b0;
         force_nop  <= 1'b0;
      end else begin
         skip_taken <= skip_now;
         force_nop  <= enter_skip;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   sequence s_exec_cycle;
      is_cmp_skip [*4] ##1 !is_cmp_skip;
   endsequence

   sequence s_skip_one;
      !force_nop ##1 force_nop [*4] ##1 !force_nop;
   endsequence

   sequence s_skip_two;
      !force_nop ##1 force_nop [*8] ##1 !force_nop;
   endsequence

   a_decode_start: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == ST_IDLE && instr_valid && instr_word[OPC_MSB:OPC_LSB] == OPC_CPSG)
         |=> (state_reg == ST_EXEC && is_cmp_skip) ##1 mem_rd)
      else $error("opcode not recognised");
   a_busy_ignores: assert property (@(posedge core_clk) disable iff (!nrst)
      (busy && instr_valid) |=> $stable(faddr_reg) && $stable(abit_reg))
      else $error("instruction taken while busy");
   a_idle_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
      !busy |-> !is_cmp_skip && !mem_rd && !skip_taken && !force_nop)
      else $error("activity while idle");
   a_read_in_exec: assert property (@(posedge core_clk) disable iff (!nrst)
      mem_rd |-> is_cmp_skip && busy)
      else $error("data read outside execute cycle");
   a_gt_by_value: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == ST_EXEC && cyc_end && mem_rdata > working_register_file_alias)
         |=> skip_taken && force_nop)
      else $error("greater byte did not skip");
   a_le_by_value: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == ST_EXEC && cyc_end && mem_rdata <= working_register_file_alias)
         |=> !skip_taken && !force_nop)
      else $error("byte not greater but skipped");
   a_skip_when_gt: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == ST_EXEC && cyc_end && greater) |=> skip_taken && state_reg == ST_SKIP1)
      else $error("greater compare did not skip");
   a_no_skip_le: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == ST_EXEC && cyc_end && !greater) |=> !skip_taken && state_reg == ST_IDLE)
      else $error("skip taken without greater");
   a_skip_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
      skip_taken |=> !skip_taken)
      else $error("skip pulse too long");
   a_nop_after_skip: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(force_nop) |-> skip_taken)
      else $error("no-op without skip decision");
   a_exec_length: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(is_cmp_skip) |-> s_exec_cycle)
      else $error("execute cycle length wrong");
   a_one_word_len: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == ST_EXEC && cyc_end && greater && !next_is_two_word) |-> s_skip_one)
      else $error("one word skip length wrong");
   a_two_word_len: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == ST_EXEC && cyc_end && greater && next_is_two_word) |-> s_skip_two)
      else $error("two word skip length wrong");
   a_busy_cover: assert property (@(posedge core_clk) disable iff (!nrst)
      (in_exec || in_skip) |-> busy)
      else $error("busy low during instruction");
   a_access_bank: assert property (@(posedge core_clk) disable iff (!nrst)
      (busy && !abit_reg && !lit_mode)
         |=> mem_addr[11:8] == ((faddr_reg < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK)
             && mem_addr[7:0] == faddr_reg)
      else $error("access bank address wrong");
   a_bank_select: assert property (@(posedge core_clk) disable iff (!nrst)
      (busy && abit_reg) |=> mem_addr == {$past(bank_select_register), $past(faddr_reg)})
      else $error("bank select address wrong");
   a_lit_offset: assert property (@(posedge core_clk) disable iff (!nrst)
      (busy && ext_set_en && !abit_reg && faddr_reg <= LIT_OFS_MAX)
         |=> mem_addr == 12'($past(index_base) + {4'h0, $past(faddr_reg)}))
      else $error("literal offset address wrong");
   a_single_read: assert property (@(posedge core_clk) disable iff (!nrst)
      mem_rd |=> !mem_rd [*3])
      else $error("extra data access");
endmodule

/* File: test/cmp_skip_gt_tb.sv */
// self-checking bench for the compare-and-skip-if-greater block
`timescale 1ns/1ps
module cmp_skip_gt_tb;
   import cmp_skip_pkg::*;
   logic        core_clk, nrst, instr_valid, next_is_two_word, ext_set_en;
   logic [15:0] instr_word;
   logic [7:0]  working_register_file_alias, mem_rdata;
   logic [3:0]  bank_select_register;
   logic [11:0] index_base, mem_addr;
   logic        is_cmp_skip, mem_rd, skip_taken, force_nop, busy;
   int          mismatches, samples_checked, cyc;
   cmp_skip_gt i_cmp_skip_gt (.core_clk(core_clk), .nrst(nrst), .instr_valid(instr_valid),
      .instr_word(instr_word), .next_is_two_word(next_is_two_word),
      .working_register_file_alias(working_register_file_alias),
      .bank_select_register(bank_select_register), .ext_set_en(ext_set_en),
      .index_base(index_base), .mem_rdata(mem_rdata), .is_cmp_skip(is_cmp_skip),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .skip_taken(skip_taken),
      .force_nop(force_nop), .busy(busy));
   ////////////////////////////////////////
   task automatic give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one instruction; nw is the number of words skipped
   task automatic run(input logic a, input logic [7:0] fa, input logic [7:0] w,
                      input logic [7:0] f, input logic two, input logic [11:0] ea, input int nw);
      int n, sk, rd, fn;
      n = 0; sk = 0; rd = 0; fn = 0;
      instr_valid = 1'b1; instr_word = {OPC_CPSG, a, fa};
      working_register_file_alias = w; mem_rdata = f; next_is_two_word = two;
      @(posedge core_clk); #2;
      instr_valid = 1'b0;
      // busy rises at the decode edge; each pass is one core_clk cycle of the instruction
      while (busy === 1'b1 && n < 20) begin
         if (n == 1) begin
            check(16'(is_cmp_skip), 16'h0001);
            check(16'(mem_addr), 16'(ea));
         end
         n++;
         if (skip_taken === 1'b1) sk++;
         if (mem_rd === 1'b1) rd++;
         if (force_nop === 1'b1) fn++;
         @(posedge core_clk); #2;
      end
      check(16'(rd), 16'h0001);
      check(16'(sk), 16'(nw > 0));
      check(16'(fn), 16'(4 * nw));
      check(16'(n), 16'(4 * (1 + nw)));
   endtask
   ////////////////////////////////////////
   task automatic t_access_bank();
      ext_set_en = 1'b0;
      run(1'b0, 8'h10, 8'h05, 8'h06, 1'b0, 12'h010, 1);
      run(1'b0, 8'h80, 8'h7f, 8'h80, 1'b1, 12'hf80, 2);
      run(1'b0, 8'hff, 8'h44, 8'h44, 1'b0, 12'hfff, 0);
   endtask
   task automatic t_bank_select();
      ext_set_en = 1'b1; bank_select_register = 4'h5;
      run(1'b1, 8'h33, 8'h90, 8'h20, 1'b1, 12'h533, 0);
      run(1'b1, 8'h00, 8'h00, 8'h01, 1'b0, 12'h500, 1);
   endtask
   task automatic t_lit_offset();
      ext_set_en = 1'b1; index_base = 12'h100;
      run(1'b0, 8'h5f, 8'h10, 8'hff, 1'b0, 12'h15f, 1);
      run(1'b0, 8'h60, 8'hff, 8'hfe, 1'b0, 12'hf60, 0);
      run(1'b0, 8'h00, 8'h00, 8'h00, 1'b1, 12'h100, 0);
   endtask
   // a second word offered during the execute cycle must not restart or re-address
   task automatic t_busy_refused();
      ext_set_en = 1'b0; bank_select_register = 4'h5; next_is_two_word = 1'b0;
      working_register_file_alias = 8'hff; mem_rdata = 8'h00;
      instr_valid = 1'b1; instr_word = {OPC_CPSG, 1'b1, 8'h44};
      @(posedge core_clk); #2;
      instr_word = {OPC_CPSG, 1'b1, 8'h55};
      repeat (3) @(posedge core_clk);
      #2;
      instr_valid = 1'b0;
      @(posedge core_clk); #2;
      check(16'(busy), 16'h0000);
      check(16'(mem_addr), 16'h0544);
   endtask
   task automatic t_refused();
      instr_valid = 1'b1; instr_word = 16'h6010;
      repeat (6) begin
         @(posedge core_clk); #2;
         instr_valid = 1'b0;
         check(16'(busy), 16'h0000);
      end
   endtask
   ////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 1000) begin
         mismatches++;
         give_verdict();
      end
   end
   initial begin
      nrst = 1'b0; instr_valid = 1'b0; instr_word = 16'h0000; next_is_two_word = 1'b0;
      working_register_file_alias = 8'h00; mem_rdata = 8'h00; bank_select_register = 4'h0;
      ext_set_en = 1'b0; index_base = 12'h000; mismatches = 0; samples_checked = 0; cyc = 0;
      repeat (10) @(posedge core_clk);
      #2;
      nrst = 1'b1;
      t_access_bank();
      t_bank_select();
      t_lit_offset();
      t_busy_refused();
      t_refused();
      give_verdict();
   end
endmodule
